/* File: sample_trigger_expansion_ctrl.sv */
// acquisition sequencer: channel list, timebase, trigger, expansion selects, apb registers
// assumes converters on ref_clk that pulse adc_done with all results; trigger and ext clock are pins
//
// Summary of operation
// - five select lines carry input number high bits, MSB on the first line
// - selects for an input settle one sample period before its conversion
// - expansion addressing covers eight boards of sixty-four inputs each
// - external trigger counts as active while high
// - trigger works one-shot or gated, chosen by configuration
// - without the hardware trigger setting the trigger pin is ignored
// - trigger pin is pulled up so an open pin reads active
// - internal sample clock is driven out; external sample clock accepted in
// - normal mode converts eight inputs at once, one per converter
// - compatibility mode converts groups of four inputs
// - each converter has a two-way input mux steered by the sequencer
// - groups are visited in any listed order; members within a group fixed
// - sample period is programmed in 20 ns steps
// - each converter result is 14 bits wide
// - four-input mode allows up to 800k per converter
// - eight-input mode limits each converter to 625k
// - the external sample clock acts on its rising edge
`timescale 1ns/1ps
`default_nettype none

module sample_trigger_expansion_ctrl
    import sample_trigger_pkg::*;
(
    input  wire logic                ref_clk,
    input  wire logic                srst,
    input  wire logic                ce,
    input  wire logic                ext_sample_clock_in,
    input  wire logic                ext_trigger_in,
    input  wire logic                adc_done,
    input  wire result_arr_t         adc_data,
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [ADDR_W-1:0]   paddr,
    input  wire logic [31:0]         pwdata,
    output logic [31:0]              prdata,
    output logic                     pready,
    output logic                     pslverr,
    output logic [EXP_W-1:0]         exp_sel,
    output logic [NUM_CONV-1:0]      mux_sel,
    output logic [NUM_CONV-1:0]      conv_start,
    output logic                     int_sample_clock_out,
    output logic                     trig_pullup_en,
    output logic                     sample_valid,
    output sample_s                  sample_out
);

    // *****************************************************************
    // link domain: ext sample clock
    // *****************************************************************
    logic lrst_s1_q;
    logic lrst_s2_q;
    logic ext_tgl_q;

    // reset reaches this domain through two flops; one toggle per rising edge
    always_ff @(posedge ext_sample_clock_in) begin
        lrst_s1_q <= srst;
        lrst_s2_q <= lrst_s1_q;
        ext_tgl_q <= lrst_s2_q ? 1'b0 : ~ext_tgl_q;
    end

    // *****************************************************************
    // pin synchronisers
    // *****************************************************************
    logic tgl_s1_q;
    logic tgl_s2_q;
    logic tgl_s3_q;
    logic trg_s1_q;
    logic trg_s2_q;
    logic trg_s3_q;

    // first stage feeds only the second; edge logic looks at stages two and three
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            tgl_s1_q <= 1'b0;
            tgl_s2_q <= 1'b0;
            tgl_s3_q <= 1'b0;
            trg_s1_q <= 1'b0;
            trg_s2_q <= 1'b0;
            trg_s3_q <= 1'b0;
        end else if (ce) begin
            tgl_s1_q <= ext_tgl_q;
            tgl_s2_q <= tgl_s1_q;
            tgl_s3_q <= tgl_s2_q;
            trg_s1_q <= ext_trigger_in;
            trg_s2_q <= trg_s1_q;
            trg_s3_q <= trg_s2_q;
        end
    end

    logic ext_ev;
    logic trig_lvl;
    logic trig_rise;
    assign ext_ev    = tgl_s2_q ^ tgl_s3_q;
    assign trig_lvl  = trg_s2_q;
    assign trig_rise = trg_s2_q & ~trg_s3_q;

    // *****************************************************************
    // registers and apb slave
    // *****************************************************************
    logic [4:0]        ctrl_q;
    logic [4:0]        ctrl_d;
    logic [IDX_W-1:0]  last_q;
    logic [IDX_W-1:0]  last_d;
    logic [15:0]       period_q;
    logic [15:0]       period_d;
    list_entry_s       list_q [LIST_DEPTH];
    list_entry_s       list_d [LIST_DEPTH];
    logic              overrun_q;
    logic              overrun_d;
    logic [31:0]       prdata_d;
    logic              pready_d;
    logic              pslverr_d;
    logic              pullup_q;
    seq_state_e        state_q;
    logic [IDX_W-1:0]  idx_q;
    logic              overrun_set;

    logic              wr_en;
    logic              hit_ctrl;
    logic              hit_period;
    logic              hit_status;
    logic              hit_list;
    logic [IDX_W-1:0]  list_sel;

    assign wr_en      = psel & penable & pready & pwrite;
    assign hit_ctrl   = (paddr == OFS_CTRL);
    assign hit_period = (paddr == OFS_PERIOD);
    assign hit_status = (paddr == OFS_STATUS);
    assign hit_list   = (paddr[11:6] == LIST_PAGE) && (paddr[1:0] == 2'b00);
    assign list_sel   = paddr[5:2];

    // one wait state: the answer is registered, then held for the sampling edge
    always_comb begin
        ctrl_d    = ctrl_q;
        last_d    = last_q;
        period_d  = period_q;
        list_d    = list_q;
        overrun_d = overrun_q;
        pready_d  = psel & penable & ~pready;
        prdata_d  = 32'h0000_0000;
        pslverr_d = 1'b0;
        if (psel & penable & ~pready) begin
            pslverr_d = ~(hit_ctrl | hit_period | hit_status | hit_list);
            if (!pwrite) begin
                if (hit_ctrl) begin
                    prdata_d[4:0] = ctrl_q;
                    prdata_d[CTRL_LAST_LSB +: IDX_W] = last_q;
                end
                if (hit_period) begin
                    prdata_d[15:0] = period_q;
                end
                if (hit_status) begin
                    prdata_d[ST_RUN_BIT]     = (state_q == SEQ_RUN);
                    prdata_d[ST_ARMED_BIT]   = (state_q == SEQ_ARMED);
                    prdata_d[ST_TRIG_BIT]    = trig_lvl;
                    prdata_d[ST_OVERRUN_BIT] = overrun_q;
                    prdata_d[ST_IDX_LSB +: IDX_W] = idx_q;
                end
                if (hit_list) begin
                    prdata_d[LIST_GROUP_LSB +: 2]   = list_q[list_sel].group;
                    prdata_d[LIST_EXP_LSB +: EXP_W] = list_q[list_sel].exp_hi;
                end
            end
        end
        if (wr_en) begin
            if (hit_ctrl) begin
                ctrl_d = pwdata[4:0];
                last_d = pwdata[CTRL_LAST_LSB +: IDX_W];
            end
            if (hit_period) begin
                period_d = pwdata[15:0];
            end
            if (hit_status && pwdata[ST_OVERRUN_BIT]) begin
                overrun_d = 1'b0;
            end
            if (hit_list) begin
                list_d[list_sel].group  = pwdata[LIST_GROUP_LSB +: 2];
                list_d[list_sel].exp_hi = pwdata[LIST_EXP_LSB +: EXP_W];
            end
        end
        // a new overrun in the clearing cycle survives
        if (overrun_set) begin
            overrun_d = 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            ctrl_q    <= CTRL_RESET;
            last_q    <= '0;
            period_q  <= PERIOD_RESET;
            overrun_q <= 1'b0;
            prdata    <= 32'h0000_0000;
            pready    <= 1'b0;
            pslverr   <= 1'b0;
            pullup_q  <= 1'b1;
            for (int i = 0; i < LIST_DEPTH; i++) begin
                list_q[i] <= '0;
            end
        end else if (ce) begin
            ctrl_q    <= ctrl_d;
            last_q    <= last_d;
            period_q  <= period_d;
            overrun_q <= overrun_d;
            prdata    <= prdata_d;
            pready    <= pready_d;
            pslverr   <= pslverr_d;
            pullup_q  <= 1'b1;
            list_q    <= list_d;
        end
    end

    assign trig_pullup_en = pullup_q;

    // *****************************************************************
    // sequencer and timebase
    // *****************************************************************
    logic run_en;
    logic group8;
    logic hw_trig;
    logic gated;
    logic ext_clk_sel;
    assign run_en      = ctrl_q[CTRL_RUN_BIT];
    assign group8      = ctrl_q[CTRL_GROUP8_BIT];
    assign hw_trig     = ctrl_q[CTRL_HWTRIG_BIT];
    assign gated       = ctrl_q[CTRL_GATED_BIT];
    assign ext_clk_sel = ctrl_q[CTRL_EXTCLK_BIT];

    seq_state_e          state_d;
    logic [IDX_W-1:0]    idx_d;
    ns_t                 phase_q;
    ns_t                 phase_d;
    ns_t                 gap_q;
    ns_t                 gap_d;
    logic [EXP_W-1:0]    exp_sel_d;
    logic [NUM_CONV-1:0] mux_sel_d;
    logic [NUM_CONV-1:0] conv_start_d;
    logic                int_clk_d;
    logic [IDX_W-1:0]    pend_entry_q;
    logic [IDX_W-1:0]    pend_entry_d;
    logic [NUM_CONV-1:0] pend_mask_q;
    logic [NUM_CONV-1:0] pend_mask_d;
    logic                sample_valid_d;
    sample_s             sample_d;

    ns_t                 per_raw;
    ns_t                 min_ns;
    ns_t                 per_ns;
    ns_t                 phase_nx;
    logic                int_tick;
    logic                src_tick;
    logic                take;
    list_entry_s         cur;
    list_entry_s         nxt;

    // converters that take part in a group; the mux picks the even or odd pin
    function automatic logic [NUM_CONV-1:0] group_mask(input logic [1:0] g, input logic g8);
        if (g8) begin
            group_mask = 8'hff;
        end else begin
            group_mask = g[1] ? 8'hf0 : 8'h0f;
        end
    endfunction

    // first select line carries the highest bit
    function automatic logic [EXP_W-1:0] order_sel(input logic [EXP_W-1:0] v);
        for (int b = 0; b < EXP_W; b++) begin
            order_sel[b] = v[EXP_W-1-b];
        end
    endfunction

    always_comb begin
        state_d        = state_q;
        idx_d          = idx_q;
        phase_d        = '0;
        gap_d          = gap_q;
        int_clk_d      = 1'b0;
        conv_start_d   = '0;
        pend_entry_d   = pend_entry_q;
        pend_mask_d    = pend_mask_q;
        overrun_set    = 1'b0;
        take           = 1'b0;
        src_tick       = 1'b0;
        int_tick       = 1'b0;
        // period clamped so no converter exceeds its mode's rate
        per_raw        = ns_t'(period_q * RES_STEP_NS);
        min_ns         = group8 ? MIN_G8_NS : MIN_G4_NS;
        per_ns         = (per_raw < min_ns) ? min_ns : per_raw;
        phase_nx       = ns_t'(phase_q + CLK_STEP_NS);
        cur            = list_q[idx_q];

        // trigger handling; without the hardware setting the pin is never looked at
        case (state_q)
            SEQ_IDLE: begin
                idx_d = '0;
                if (run_en) begin
                    state_d = hw_trig ? SEQ_ARMED : SEQ_RUN;
                end
            end
            SEQ_ARMED: begin
                if (!run_en) begin
                    state_d = SEQ_IDLE;
                end else if (!hw_trig) begin
                    state_d = SEQ_RUN;
                end else if (gated ? trig_lvl : trig_rise) begin
                    state_d = SEQ_RUN;
                end
            end
            SEQ_RUN: begin
                if (!run_en) begin
                    state_d = SEQ_IDLE;
                end else if (hw_trig && gated && !trig_lvl) begin
                    state_d = SEQ_ARMED;
                end
            end
            default: begin
                state_d = SEQ_IDLE;
            end
        endcase

        // fractional phase keeps the 20 ns grid on average at a 100 ns clock
        if (state_q == SEQ_RUN && state_d == SEQ_RUN) begin
            if (ext_clk_sel) begin
                src_tick = ext_ev;
            end else if (phase_nx >= per_ns) begin
                int_tick = 1'b1;
                phase_d  = ns_t'(phase_nx - per_ns);
            end else begin
                phase_d  = phase_nx;
            end
            if (!ext_clk_sel) begin
                src_tick = int_tick;
            end
        end
        int_clk_d = int_tick;

        // internal ticks already keep the clamped period; a too-early external edge is dropped and flagged
        if (src_tick) begin
            if (int_tick || gap_q >= min_ns) begin
                take = 1'b1;
            end else begin
                overrun_set = 1'b1;
            end
        end
        if (take) begin
            gap_d = CLK_STEP_NS;   // one cycle has passed when this is next read
        end else if (gap_q < GAP_SAT_NS) begin
            gap_d = ns_t'(gap_q + CLK_STEP_NS);
        end

        // convert the current entry and move the selects on to the next one
        if (take) begin
            conv_start_d = group_mask(cur.group, group8);
            pend_entry_d = idx_q;
            pend_mask_d  = conv_start_d;
            idx_d        = (idx_q == last_q) ? '0 : IDX_W'(idx_q + 1'b1);
        end
        nxt       = list_q[idx_d];
        // selects show the entry to be converted a whole period ahead
        exp_sel_d = order_sel(nxt.exp_hi);
        mux_sel_d = {NUM_CONV{nxt.group[0]}};

        // results come back as one word per converter
        sample_valid_d = adc_done;
        sample_d       = sample_out;
        if (adc_done) begin
            sample_d.entry = pend_entry_q;
            sample_d.mask  = pend_mask_q;
            sample_d.data  = adc_data;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            state_q              <= SEQ_IDLE;
            idx_q                <= '0;
            phase_q              <= '0;
            gap_q                <= GAP_SAT_NS;
            exp_sel              <= '0;
            mux_sel              <= '0;
            conv_start           <= '0;
            int_sample_clock_out <= 1'b0;
            pend_entry_q         <= '0;
            pend_mask_q          <= '0;
            sample_valid         <= 1'b0;
            sample_out           <= '0;
        end else if (ce) begin
            state_q              <= state_d;
            idx_q                <= idx_d;
            phase_q              <= phase_d;
            gap_q                <= gap_d;
            exp_sel              <= exp_sel_d;
            mux_sel              <= mux_sel_d;
            conv_start           <= conv_start_d;
            int_sample_clock_out <= int_clk_d;
            pend_entry_q         <= pend_entry_d;
            pend_mask_q          <= pend_mask_d;
            sample_valid         <= sample_valid_d;
            sample_out           <= sample_d;
        end
    end

endmodule

`default_nettype wire

/* File: sample_trigger_pkg.sv */
// constants, field layouts and carrier types for the sample trigger and expansion sequencer
// assumes a 10 MHz ref_clk and an APB master with 32-bit data and 12-bit byte addresses
package sample_trigger_pkg;

    // *****************************************************************
    // timing
    // *****************************************************************
    localparam int unsigned CLK_PERIOD_NS    = 100;   // ref_clk period
    localparam int unsigned PERIOD_RES_NS    = 20;    // one step of the period register
    localparam int unsigned MIN_PERIOD_G4_NS = 1250;  // 800k per converter
    localparam int unsigned MIN_PERIOD_G8_NS = 1600;  // 625k per converter
    localparam int unsigned NS_W             = 22;
    typedef logic [NS_W-1:0] ns_t;
    localparam ns_t CLK_STEP_NS = ns_t'(CLK_PERIOD_NS);
    localparam ns_t RES_STEP_NS = ns_t'(PERIOD_RES_NS);
    localparam ns_t MIN_G4_NS   = ns_t'(MIN_PERIOD_G4_NS);
    localparam ns_t MIN_G8_NS   = ns_t'(MIN_PERIOD_G8_NS);
    localparam ns_t GAP_SAT_NS  = ns_t'(MIN_PERIOD_G8_NS);

    // *****************************************************************
    // sizes
    // *****************************************************************
    localparam int unsigned NUM_CONV   = 8;
    localparam int unsigned RESULT_W   = 14;
    localparam int unsigned EXP_W      = 5;
    localparam int unsigned LIST_DEPTH = 16;
    localparam int unsigned IDX_W      = 4;
    localparam int unsigned ADDR_W     = 12;

    // *****************************************************************
    // register map
    // *****************************************************************
    localparam logic [ADDR_W-1:0] OFS_CTRL   = 12'h000;
    localparam logic [ADDR_W-1:0] OFS_PERIOD = 12'h004;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 12'h008;
    localparam logic [5:0]        LIST_PAGE  = 6'h01;     // entries at 0x040 + 4*i
    localparam int unsigned CTRL_RUN_BIT    = 0;
    localparam int unsigned CTRL_GROUP8_BIT = 1;
    localparam int unsigned CTRL_HWTRIG_BIT = 2;
    localparam int unsigned CTRL_GATED_BIT  = 3;
    localparam int unsigned CTRL_EXTCLK_BIT = 4;
    localparam int unsigned CTRL_LAST_LSB   = 8;
    localparam int unsigned ST_RUN_BIT      = 0;
    localparam int unsigned ST_ARMED_BIT    = 1;
    localparam int unsigned ST_TRIG_BIT     = 2;
    localparam int unsigned ST_OVERRUN_BIT  = 3;
    localparam int unsigned ST_IDX_LSB      = 8;
    localparam int unsigned LIST_GROUP_LSB  = 0;
    localparam int unsigned LIST_EXP_LSB    = 4;
    localparam logic [4:0]  CTRL_RESET      = 5'h02;      // eight-input groups, stopped
    localparam logic [15:0] PERIOD_RESET    = 16'h0050;   // 80 steps, 1600 ns

    // *****************************************************************
    // carriers
    // *****************************************************************
    typedef enum logic [1:0] {
        SEQ_IDLE  = 2'b00,
        SEQ_ARMED = 2'b01,
        SEQ_RUN   = 2'b11
    } seq_state_e;

    typedef struct packed {
        logic [EXP_W-1:0] exp_hi;   // high five bits of the input number
        logic [1:0]       group;
    } list_entry_s;

    typedef logic [NUM_CONV-1:0][RESULT_W-1:0] result_arr_t;

    typedef struct packed {
        logic [IDX_W-1:0]    entry;
        logic [NUM_CONV-1:0] mask;
        result_arr_t         data;
    } sample_s;

endpackage

/* File: stx_props.sv */
// checker: apb handshake, tick spacing, group masks, sample hand-off
// assumes a bind into the sequencer top with ce held high
`timescale 1ns/1ps
`default_nettype none
module stx_props
    import sample_trigger_pkg::*;
(
    input wire logic                ref_clk,
    input wire logic                srst,
    input wire logic                psel,
    input wire logic                penable,
    input wire logic                pready,
    input wire logic                pslverr,
    input wire logic                adc_done,
    input wire logic [NUM_CONV-1:0] mux_sel,
    input wire logic [NUM_CONV-1:0] conv_start,
    input wire logic                int_sample_clock_out,
    input wire logic                trig_pullup_en,
    input wire logic                sample_valid
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (srst);
    // ****************
    // properties
    // ****************
    a_pullup_held: assert property (trig_pullup_en) else $error("trigger pull-up off");
    a_ready_wait: assert property (psel && !penable |=> !pready ##1 pready) else $error("ready not after one wait");
    a_ready_pulse: assert property (pready |=> !pready) else $error("ready longer than one cycle");
    a_err_ready: assert property (pslverr |-> pready) else $error("error without ready");
    a_valid_timing: assert property (sample_valid == $past(adc_done)) else $error("sample hand-off late");
    a_tick_gap: assert property (conv_start != '0 |=> (conv_start == '0) [*8]) else $error("ticks too close");
    a_group_mask: assert property (conv_start != '0 |-> conv_start inside {8'h0f, 8'hf0, 8'hff})
        else $error("bad converter group");
    a_mux_common: assert property (mux_sel == 8'h00 || mux_sel == 8'hff) else $error("mux selects split");
    a_clk_out_tick: assert property (int_sample_clock_out |-> conv_start != '0) else $error("clock out off tick");
    // main scenarios reached
    c_half_group: cover property (conv_start == 8'hf0);
    c_refused: cover property (pslverr);
    c_sample: cover property (sample_valid);
endmodule
`default_nettype wire

/* File: conv_model.sv */
// converter bank model: latches selects, answers with a coded result
// assumes the sequencer's ref_clk; slow picks the longer conversion
`timescale 1ns/1ps
`default_nettype none
module conv_model
    import sample_trigger_pkg::*;
(
    input  wire logic                ref_clk,
    input  wire logic                slow,
    input  wire logic [EXP_W-1:0]    exp_sel,
    input  wire logic [NUM_CONV-1:0] mux_sel,
    input  wire logic [NUM_CONV-1:0] conv_start,
    output logic                     adc_done,
    output result_arr_t              adc_data
);
    logic [EXP_W-1:0]    exp_q;
    logic [NUM_CONV-1:0] mux_q;
    logic [3:0]          cnt = '0;
    result_arr_t         hold;
    initial adc_done = 1'b0;
    initial adc_data = '0;
    // selects taken as settled before the start edge; idle data toggles
    always @(posedge ref_clk) begin
        exp_q <= exp_sel;
        mux_q <= mux_sel;
        adc_done <= 1'b0;
        adc_data <= ~adc_data;
        if (conv_start != '0) begin
            for (int k = 0; k < NUM_CONV; k++)
                hold[k] <= {exp_q, mux_q[k], 3'(k), 5'h15};
            cnt <= slow ? 4'h9 : 4'h2;
        end else if (cnt == 4'h1) begin
            adc_done <= 1'b1;
            adc_data <= hold;
            cnt <= '0;
        end else if (cnt != '0) begin
            cnt <= cnt - 4'h1;
        end
    end
endmodule
`default_nettype wire

/* File: sample_trigger_expansion_ctrl_test.sv */
// bench: apb tasks, timing, sample, trigger and external clock tests
// assumes conv_model and stx_props are compiled first
`timescale 1ns/1ps
`default_nettype none
module sample_trigger_expansion_ctrl_test
    import sample_trigger_pkg::*;
;
    logic              ref_clk = 0, srst = 1, ext_clk = 0, ext_run = 1, trig = 0, slow = 1;
    logic              psel = 0, penable = 0, pwrite = 0, pready, pslverr, adc_done, sample_valid, int_clk, e;
    logic [ADDR_W-1:0] paddr = '0;
    logic [31:0]       pwdata = '0, prdata, q, le;
    logic [EXP_W-1:0]  exp_sel;
    logic [7:0]        mux_sel, conv_start, mk;
    result_arr_t       adc_data;
    sample_s           sample_out;
    logic [31:0]       lst [2] = '{32'h132, 32'h041};
    int                fail_count = 0, check_count = 0, w, c;
    always #50 ref_clk = ~ref_clk;
    // link clock stands still outside frames
    always #62.5 ext_clk = ext_run ? ~ext_clk : 1'b0;
    sample_trigger_expansion_ctrl dut (.ref_clk(ref_clk), .srst(srst), .ce(1'b1), .ext_sample_clock_in(ext_clk),
        .ext_trigger_in(trig), .adc_done(adc_done), .adc_data(adc_data), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .exp_sel(exp_sel), .mux_sel(mux_sel), .conv_start(conv_start), .int_sample_clock_out(int_clk),
        .trig_pullup_en(), .sample_valid(sample_valid), .sample_out(sample_out));
    conv_model u_conv (.ref_clk(ref_clk), .slow(slow), .exp_sel(exp_sel), .mux_sel(mux_sel),
        .conv_start(conv_start), .adc_done(adc_done), .adc_data(adc_data));
    // ****************
    // tasks
    // ****************
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // request held until pready is sampled high, then released
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int t;
        t = 0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        do begin @(posedge ref_clk); t++; end while (pready !== 1'b1 && t < 20);
        if (t >= 20) fail_count++;
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge ref_clk);
    endtask
    task automatic tick(output int n);
        n = 0;
        do begin @(posedge ref_clk); n++; end while (conv_start === '0 && n < 400);
    endtask
    task automatic count(input int len, output int t);
        t = 0;
        repeat (len) begin @(posedge ref_clk); t += (conv_start !== '0); end
    endtask
    task automatic stop();
        apb(1, 12'h000, 32'h0);
        repeat (20) @(posedge ref_clk);
    endtask
    function automatic logic [4:0] rev(input logic [4:0] v);
        return {v[0], v[1], v[2], v[3], v[4]};
    endfunction
    // cycles from first to fifth tick, period clamped to the group minimum
    function automatic int span(input int per, input bit g8);
        int p;
        p = per * PERIOD_RES_NS;
        if (p < (g8 ? 1600 : 1250)) p = g8 ? 1600 : 1250;
        return (5 * p + 99) / 100 - (p + 99) / 100;
    endfunction
    initial begin
        #1000000;
        fail_count++;
        complete_run();
    end
    initial begin
        repeat (3) @(posedge ref_clk);
        srst <= 1'b0;
        repeat (5) @(posedge ref_clk);
        ext_run <= 1'b0;
        apb(0, 12'h000, 0); check(q, 32'h2); check(e, 0);
        apb(0, 12'h004, 0); check(q, 32'h50);
        apb(0, 12'h00c, 0); check(e, 1); check(q, 0);
        apb(1, 12'h040, lst[0]);
        apb(1, 12'h044, lst[1]);
        apb(0, 12'h040, 0); check(q, lst[0]);
        $display("test registers done");
        for (int j = 0; j < 3; j++) begin
            apb(1, 12'h004, j == 2 ? 91 : 1);
            apb(1, 12'h000, j == 1 ? 32'h101 : 32'h103);
            tick(w); check(int_clk, 1);
            c = 0;
            repeat (4) begin tick(w); c += w; end
            check(c, span(j == 2 ? 91 : 1, j != 1));
            stop();
        end
        $display("test period done");
        apb(1, 12'h004, 32'h50);
        for (int g = 1; g >= 0; g--) begin
            apb(1, 12'h000, 32'h101 | (g << 1));
            for (int i = 0; i < 3; i++) begin
                le = lst[i % 2];
                mk = g ? 8'hff : (le[1] ? 8'hf0 : 8'h0f);
                w = 0;
                do begin @(posedge ref_clk); w++; end while (sample_valid !== 1'b1 && w < 300);
                check(sample_out.entry, i % 2);
                check(sample_out.mask, mk);
                check(exp_sel, rev(lst[(i + 1) % 2][8:4]));
                for (int k = 0; k < 8; k++)
                    if (mk[k]) check(sample_out.data[k], {rev(le[8:4]), le[0], 3'(k), 5'h15});
            end
            stop();
        end
        $display("test samples done");
        apb(1, 12'h000, 32'h105);
        count(40, c); check(c, 0);
        apb(0, 12'h008, 0); check(q, 32'h2);
        trig <= 1'b1;
        tick(w); check(w < 30, 1);
        apb(1, 12'h000, 32'h10d);
        count(40, c); check(c > 1, 1);
        trig <= 1'b0;
        repeat (5) @(posedge ref_clk);
        count(40, c); check(c, 0);
        stop();
        $display("test trigger done");
        apb(1, 12'h000, 32'h113);
        ext_run <= 1'b1;
        count(50, c);
        ext_run <= 1'b0;
        check(c >= 2 && c <= 4, 1);
        repeat (10) @(posedge ref_clk);
        stop();
        apb(0, 12'h008, 0); check(q[3], 1);
        apb(1, 12'h008, 32'h8);
        apb(0, 12'h008, 0); check(q[3], 0);
        $display("test external clock done");
        complete_run();
    end
endmodule
bind sample_trigger_expansion_ctrl stx_props u_props (.ref_clk(ref_clk), .srst(srst), .psel(psel),
    .penable(penable), .pready(pready), .pslverr(pslverr), .adc_done(adc_done), .mux_sel(mux_sel),
    .conv_start(conv_start), .int_sample_clock_out(int_sample_clock_out), .trig_pullup_en(trig_pullup_en),
    .sample_valid(sample_valid));
`default_nettype wire
